// ### core/acd_defines.vh
// Constants for the arithmetic decoder: offsets, fields, opcodes, reset values.
`ifndef ACD_DEFINES_VH
`define ACD_DEFINES_VH

// ==================================================
// Register byte offsets on APB.
`define ACD_OFF_COND    12'h000
`define ACD_OFF_STAT    12'h004
`define ACD_OFF_MASK    12'h008
`define ACD_OFF_CTRL    12'h00c
`define ACD_OFF_RES     12'h010

// ==================================================
// Condition flag bit positions.
`define ACD_CF_POS      3
`define ACD_CF_ZERO     2
`define ACD_CF_NEG      1
`define ACD_CF_OVF      0

// ==================================================
// Event bits in status and mask.
`define ACD_EV_OVF      0
`define ACD_EV_DONE     1
`define ACD_EV_SKIP     2
`define ACD_EV_W        3

// ==================================================
// Opcodes.
`define ACD_OP12_RR     12'h010
`define ACD_OP_AOR      6'h34
`define ACD_OP_ARM      6'h26
`define ACD_OP_AEM      6'h27
`define ACD_OP_AAM      6'h28
`define ACD_OP_DVM      6'h2f
`define ACD_OP_DVO      6'h31

// ==================================================
// Register select codes.
`define ACD_R_NONE      3'h0
`define ACD_R_I         3'h1
`define ACD_R_J         3'h2
`define ACD_R_K         3'h3
`define ACD_R_E         3'h4
`define ACD_R_A         3'h5
`define ACD_R_T         3'h6

// ==================================================
// Reset values.
`define ACD_COND_RST    4'h0
`define ACD_MASK_RST    3'h0
`define ACD_CTRL_RST    1'h1

`endif

// ### core/acd_flags.v
// Ripple adder with sign-bit carry tracking and condition flag evaluation.
`timescale 1ns/1ps
`default_nettype none
`include "acd_defines.vh"

module acd_flags (
	input  wire [23:0] opa,
	input  wire [23:0] opb,
	output wire [23:0] sum,
	output wire [3:0]  cond
);

	wire [24:0] carry;

	// ==================================================
	// Carry chain, one cell per bit.
	assign carry[0] = 1'b0;
	genvar i;
	generate
		for (i = 0; i < 24; i = i + 1) begin : g_bit
			assign sum[i]     = opa[i] ^ opb[i] ^ carry[i];
			assign carry[i+1] = (opa[i] & opb[i]) | (carry[i] & (opa[i] ^ opb[i]));
		end
	endgenerate

	// ==================================================
	// Flags over the whole 24-bit result, sign bit read as two's complement.
	assign cond[`ACD_CF_POS]  = ~sum[23] & (|sum);
	assign cond[`ACD_CF_ZERO] = ~(|sum);
	assign cond[`ACD_CF_NEG]  = sum[23];
	// Carry into the sign position differing from carry out means overflow.
	assign cond[`ACD_CF_OVF]  = carry[23] ^ carry[24];

endmodule
`default_nettype wire

// ### core/acd_core.v
// Instruction word decoder and add-group executor with condition flags.
//
// Summary of operation
// - Whole instruction comes from one 24-bit word.
// - Recognise six or twelve bit opcodes, extended.
// - Memory format: opcode, indirect, index, 15-bit address.
// - Result goes to second operand, first kept.
// - Multiply, divide style ops skip that convention.
// - Every arithmetic op updates the condition register; here divide and other K_NONE words leave it unchanged.
// - Bit 3 set when result is positive.
// - Bit 2 set when result is zero.
// - Bit 1 set when result is negative.
// - Bit 0 set on sign carry mismatch.
// - Add immediate treats 15-bit operand unsigned.
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "acd_defines.vh"

module acd_core (
	input  wire        clk,
	input  wire        nrst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        instr_valid,
	input  wire [23:0] instr_word,
	input  wire [23:0] instr_mem_data,
	output reg         instr_ready,
	output reg  [5:0]  dec_op6,
	output reg  [11:0] dec_op12,
	output reg         dec_op_long,
	output reg         dec_op_ext,
	output reg         dec_indirect,
	output reg  [1:0]  dec_index,
	output reg  [14:0] dec_addr,
	output reg  [2:0]  rf_rd_sel_a,
	output reg  [2:0]  rf_rd_sel_b,
	input  wire [23:0] rf_rd_data_a,
	input  wire [23:0] rf_rd_data_b,
	output reg         rf_wr_en,
	output reg  [2:0]  rf_wr_sel,
	output reg  [23:0] rf_wr_data,
	output reg         mem_wr_en,
	output reg  [23:0] mem_wr_data,
	output reg  [3:0]  cond_flags,
	output reg         irq
);

	// ==================================================
	// Local encodings.
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_READ = 3'b010;
	localparam [2:0] ST_EXEC = 3'b100;

	localparam [3:0] K_NONE = 4'b0001;
	localparam [3:0] K_RR   = 4'b0010;
	localparam [3:0] K_OPND = 4'b0100;
	localparam [3:0] K_RMEM = 4'b1000;

	// ==================================================
	// State.
	reg  [2:0]            state_r;
	reg  [3:0]            kind_r;
	reg  [3:0]            kind_nxt;
	reg  [23:0]           mem_r;
	reg  [23:0]           opa_r;
	reg  [23:0]           opb_r;
	reg  [2:0]            dst_r;
	reg  [2:0]            sel_a_nxt;
	reg  [2:0]            sel_b_nxt;
	reg  [`ACD_EV_W-1:0]  stat_r;
	reg  [`ACD_EV_W-1:0]  mask_r;
	reg                   enable_r;
	reg  [23:0]           result_r;
	reg  [`ACD_EV_W-1:0]  ev_set;
	wire [`ACD_EV_W-1:0]  ev_clr;
	wire [`ACD_EV_W-1:0]  stat_nxt;
	wire [23:0]           sum;
	wire [3:0]            cond;
	wire                  take;
	wire                  apb_setup;
	wire                  apb_wr;
	wire [5:0]            w_op6;
	wire [2:0]            r1_code;
	wire [2:0]            r2_code;

	// ==================================================
	// Adder and flag evaluation shared by every add form.
	acd_flags u_flags (
		.opa  (opa_r),
		.opb  (opb_r),
		.sum  (sum),
		.cond (cond)
	);

	// Maps a one-hot register field to a select code; not one-hot gives none.
	function [2:0] onehot_code;
		input [5:0] f;
		begin
			case (f)
				6'h01:   onehot_code = `ACD_R_I;
				6'h02:   onehot_code = `ACD_R_J;
				6'h04:   onehot_code = `ACD_R_K;
				6'h08:   onehot_code = `ACD_R_E;
				6'h10:   onehot_code = `ACD_R_A;
				6'h20:   onehot_code = `ACD_R_T;
				default: onehot_code = `ACD_R_NONE;
			endcase
		end
	endfunction

	// ==================================================
	// Field extraction straight from the presented word.
	assign take    = instr_valid & instr_ready;
	assign w_op6   = instr_word[23:18];
	assign r1_code = onehot_code(instr_word[11:6]);
	assign r2_code = onehot_code(instr_word[5:0]);

	// Classify the word and pick the register reads it needs: two for register to register, one for the other add forms, none for K_NONE.
	always @* begin
		kind_nxt  = K_NONE;
		sel_a_nxt = `ACD_R_NONE;
		sel_b_nxt = `ACD_R_NONE;
		if (instr_word[23:12] == `ACD_OP12_RR) begin
			// Twelve-bit opcode, register to register add.
			if (r1_code != `ACD_R_NONE && r2_code != `ACD_R_NONE) begin
				kind_nxt  = K_RR;
				sel_a_nxt = r1_code;
				sel_b_nxt = r2_code;
			end
		end else if (w_op6 == `ACD_OP_AOR) begin
			// Register code sits in the three bits after the opcode.
			if (instr_word[17:15] != `ACD_R_NONE && instr_word[17:15] != 3'h7) begin
				kind_nxt  = K_OPND;
				sel_b_nxt = instr_word[17:15];
			end
		end else if (w_op6 == `ACD_OP_ARM) begin
			// Index field names I, J or K as the addend.
			if (instr_word[16:15] != 2'h0) begin
				kind_nxt  = K_RMEM;
				sel_b_nxt = {1'b0, instr_word[16:15]};
			end
		end else if (w_op6 == `ACD_OP_AEM) begin
			kind_nxt  = K_RMEM;
			sel_b_nxt = `ACD_R_E;
		end else if (w_op6 == `ACD_OP_AAM) begin
			kind_nxt  = K_RMEM;
			sel_b_nxt = `ACD_R_A;
		end
		// Divide and anything else unknown stay K_NONE and place no result.
	end

	// ==================================================
	// Decode outputs, latched when a word is accepted.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dec_op6      <= 6'h00;
			dec_op12     <= 12'h000;
			dec_op_long  <= 1'b0;
			dec_op_ext   <= 1'b0;
			dec_indirect <= 1'b0;
			dec_index    <= 2'h0;
			dec_addr     <= 15'h0000;
			mem_r        <= 24'h000000;
		end else if (take) begin
			dec_op6      <= w_op6;
			dec_op12     <= instr_word[23:12];
			// A zero leading digit pair marks a twelve-bit opcode.
			dec_op_long  <= (w_op6 == 6'h00);
			// A zero twelve-bit code carries the opcode on into the next field.
			dec_op_ext   <= (instr_word[23:12] == 12'h000);
			dec_indirect <= instr_word[17];
			dec_index    <= instr_word[16:15];
			dec_addr     <= instr_word[14:0];
			mem_r        <= instr_mem_data;
		end
	end

	// ==================================================
	// Sequencer: accept, read operands, execute, then ready again.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r     <= ST_IDLE;
			kind_r      <= K_NONE;
			instr_ready <= 1'b0;
			rf_rd_sel_a <= `ACD_R_NONE;
			rf_rd_sel_b <= `ACD_R_NONE;
			dst_r       <= `ACD_R_NONE;
			opa_r       <= 24'h000000;
			opb_r       <= 24'h000000;
		end else begin
			case (state_r)
				ST_IDLE: begin
					instr_ready <= enable_r & ~take;
					if (take) begin
						kind_r      <= kind_nxt;
						rf_rd_sel_a <= sel_a_nxt;
						rf_rd_sel_b <= sel_b_nxt;
						dst_r       <= sel_b_nxt;
						state_r     <= ST_READ;
					end
				end
				ST_READ: begin
					// Register file answers in the cycle after the select.
					case (kind_r)
						K_RR: begin
							opa_r <= rf_rd_data_a;
							opb_r <= rf_rd_data_b;
						end
						K_OPND: begin
							opa_r <= {9'h000, dec_addr};
							opb_r <= rf_rd_data_b;
						end
						K_RMEM: begin
							opa_r <= rf_rd_data_b;
							opb_r <= mem_r;
						end
						default: begin
							opa_r <= 24'h000000;
							opb_r <= 24'h000000;
						end
					endcase
					state_r <= ST_EXEC;
				end
				ST_EXEC: begin
					state_r     <= ST_IDLE;
					instr_ready <= enable_r;
				end
				default: begin
					state_r     <= ST_IDLE;
					instr_ready <= 1'b0;
				end
			endcase
		end
	end

	// ==================================================
	// Result write-back and condition update in the execute cycle.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rf_wr_en    <= 1'b0;
			rf_wr_sel   <= `ACD_R_NONE;
			rf_wr_data  <= 24'h000000;
			mem_wr_en   <= 1'b0;
			mem_wr_data <= 24'h000000;
			cond_flags  <= `ACD_COND_RST;
			result_r    <= 24'h000000;
		end else begin
			rf_wr_en  <= 1'b0;
			mem_wr_en <= 1'b0;
			if (state_r == ST_EXEC && kind_r != K_NONE) begin
				cond_flags <= cond;
				result_r   <= sum;
				if (kind_r == K_RMEM) begin
					// Memory is the destination; the register is only read.
					mem_wr_en   <= 1'b1;
					mem_wr_data <= sum;
				end else begin
					// Same register named twice simply gets the doubled value.
					rf_wr_en   <= 1'b1;
					rf_wr_sel  <= dst_r;
					rf_wr_data <= sum;
				end
			end
			// Exempt kinds leave results and flags unchanged.
		end
	end

	// ==================================================
	// Events raised by execution.
	always @* begin
		ev_set = {`ACD_EV_W{1'b0}};
		if (state_r == ST_EXEC) begin
			ev_set[`ACD_EV_DONE] = 1'b1;
			ev_set[`ACD_EV_OVF]  = (kind_r != K_NONE) & cond[`ACD_CF_OVF];
			ev_set[`ACD_EV_SKIP] = (kind_r == K_NONE);
		end
	end

	// ==================================================
	// APB decode. The slave answers in the first access cycle.
	assign apb_setup = psel & ~penable;
	assign apb_wr    = psel & penable & pready & pwrite;
	assign ev_clr    = (apb_wr && paddr == `ACD_OFF_STAT) ? pwdata[`ACD_EV_W-1:0]
	                   : {`ACD_EV_W{1'b0}};
	// A new event wins over a clear landing in the same cycle.
	assign stat_nxt  = (stat_r & ~ev_clr) | ev_set;

	// Status, mask, control and interrupt line.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stat_r   <= {`ACD_EV_W{1'b0}};
			mask_r   <= `ACD_MASK_RST;
			enable_r <= `ACD_CTRL_RST;
			irq      <= 1'b0;
		end else begin
			stat_r <= stat_nxt;
			if (apb_wr && paddr == `ACD_OFF_MASK) begin
				mask_r <= pwdata[`ACD_EV_W-1:0];
			end
			// Clearing enable only stops new words; one in flight finishes.
			if (apb_wr && paddr == `ACD_OFF_CTRL) begin
				enable_r <= pwdata[0];
			end
			irq <= |(stat_nxt & mask_r);
		end
	end

	// Read data and ready are built at the setup edge so they are flops.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= apb_setup;
			pslverr <= 1'b0;
			if (apb_setup) begin
				case (paddr)
					`ACD_OFF_COND: prdata <= {28'h0000000, cond_flags};
					`ACD_OFF_STAT: prdata <= {29'h00000000, stat_r};
					`ACD_OFF_MASK: prdata <= {29'h00000000, mask_r};
					`ACD_OFF_CTRL: prdata <= {31'h00000000, enable_r};
					`ACD_OFF_RES:  prdata <= {8'h00, result_r};
					default: begin
						prdata  <= 32'h00000000;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// ### sim/acd_props.sv
// Checker of decode, write-back and flag timing at the core's ports.
`timescale 1ns/1ps
`default_nettype none
// ========
module acd_props (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        instr_valid,
	input wire logic        instr_ready,
	input wire logic [23:0] instr_word,
	input wire logic [5:0]  dec_op6,
	input wire logic [11:0] dec_op12,
	input wire logic        dec_op_long,
	input wire logic        dec_op_ext,
	input wire logic        dec_indirect,
	input wire logic [1:0]  dec_index,
	input wire logic [14:0] dec_addr,
	input wire logic        rf_wr_en,
	input wire logic [23:0] rf_wr_data,
	input wire logic        mem_wr_en,
	input wire logic [23:0] mem_wr_data,
	input wire logic [3:0]  cond_flags
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// A word is taken where valid meets ready.
	wire logic take;
	assign take = instr_valid & instr_ready;
	sequence s_take; take; endsequence
	sequence s_busy; !instr_ready [*2]; endsequence
	property p_busy; s_take |=> s_busy; endproperty
	a_busy: assert property (p_busy) else $error("ready during execution");
	property p_dec; s_take |=> dec_op6 == $past(instr_word[23:18]) && dec_indirect ==
		$past(instr_word[17]) && dec_index == $past(instr_word[16:15]) &&
		dec_addr == $past(instr_word[14:0]); endproperty
	a_dec: assert property (p_dec) else $error("field split wrong");
	property p_long; s_take |=> dec_op12 == $past(instr_word[23:12]) &&
		dec_op_long == ($past(instr_word[23:18]) == 6'h00) &&
		dec_op_ext == ($past(instr_word[23:12]) == 12'h000); endproperty
	a_long: assert property (p_long) else $error("long opcode wrong");
	property p_wr; $rose(rf_wr_en) || $rose(mem_wr_en) |-> $past(take, 3); endproperty
	a_wr: assert property (p_wr) else $error("write not three after take");
	property p_pulse; rf_wr_en || mem_wr_en |=> !rf_wr_en && !mem_wr_en; endproperty
	a_pulse: assert property (p_pulse) else $error("write pulse too long");
	property p_rflags; rf_wr_en |-> cond_flags[3:1] == {!rf_wr_data[23] && |rf_wr_data,
		~|rf_wr_data, rf_wr_data[23]}; endproperty
	a_rflags: assert property (p_rflags) else $error("register flags wrong");
	property p_mflags; mem_wr_en |-> cond_flags[3:1] == {!mem_wr_data[23] && |mem_wr_data,
		~|mem_wr_data, mem_wr_data[23]}; endproperty
	a_mflags: assert property (p_mflags) else $error("memory flags wrong");
	property p_still; $changed(cond_flags) |-> rf_wr_en || mem_wr_en; endproperty
	a_still: assert property (p_still) else $error("flags moved without result");
	property p_apb; psel && !penable |=> pready ##1 !pready; endproperty
	a_apb: assert property (p_apb) else $error("bus answer timing wrong");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error without ready");
endmodule
bind acd_core acd_props u_props (.clk, .nrst, .psel, .penable, .pready, .pslverr,
	.instr_valid, .instr_ready, .instr_word, .dec_op6, .dec_op12, .dec_op_long, .dec_op_ext,
	.dec_indirect,
	.dec_index, .dec_addr, .rf_wr_en, .rf_wr_data, .mem_wr_en, .mem_wr_data, .cond_flags);
`default_nettype wire

// ### sim/acd_rf_model.sv
// General register file model that answers reads combinationally.
`timescale 1ns/1ps
`default_nettype none
// ========
module acd_rf_model (
	input  wire logic        clk,
	input  wire logic [2:0]  sel_a,
	input  wire logic [2:0]  sel_b,
	output wire logic [23:0] rd_a,
	output wire logic [23:0] rd_b,
	input  wire logic        wr_en,
	input  wire logic [2:0]  wr_sel,
	input  wire logic [23:0] wr_data
);
	logic [23:0] rf [0:7];
	// Code zero selects nothing, so a toggling pattern exposes any use of it.
	assign rd_a = (sel_a == 3'h0) ? {12{clk, ~clk}} : rf[sel_a];
	assign rd_b = (sel_b == 3'h0) ? {12{~clk, clk}} : rf[sel_b];
	// Write-back lands on the edge that sees the pulse.
	always @(posedge clk) begin
		if (wr_en)
			rf[wr_sel] <= wr_data;
	end
endmodule
`default_nettype wire

// ### sim/arith_cond_code_decoder_test.sv
// Self-checking bench for the decoder core, its flags and its registers.
`timescale 1ns/1ps
`default_nettype none
module arith_cond_code_decoder_test;
	// ========
	// One arithmetic case: word, operands, expected result and flags.
	typedef struct packed {
		logic [23:0] w;
		logic [2:0]  sa;
		logic [23:0] va;
		logic [2:0]  sb;
		logic [23:0] vb;
		logic [23:0] m;
		logic [23:0] d;
		logic [3:0]  c;
		logic        mw;
	} acd_row_t;
	logic        clk, nrst, psel, penable, pwrite, instr_valid, err, w_rf, w_mem;
	logic        pready, pslverr, instr_ready, dec_op_long, dec_op_ext, dec_indirect;
	logic        rf_wr_en, mem_wr_en, irq;
	logic [11:0] paddr, dec_op12;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0]  dec_op6;
	logic [1:0]  dec_index;
	logic [14:0] dec_addr;
	logic [2:0]  rf_rd_sel_a, rf_rd_sel_b, rf_wr_sel;
	logic [23:0] instr_word, instr_mem_data, rf_rd_data_a, rf_rd_data_b, rf_wr_data;
	logic [23:0] mem_wr_data;
	logic [3:0]  cond_flags;
	int          fail_count = 0, checks_done = 0, cycles = 0;
	acd_row_t    rows [7] = '{
		'{24'h010042, 3'h1, 24'h000001, 3'h2, 24'h000002, 24'h0, 24'h000003, 4'h8, 1'b0},
		'{24'h010041, 3'h1, 24'h400000, 3'h1, 24'h400000, 24'h0, 24'h800000, 4'h3, 1'b0},
		'{24'h010808, 3'h6, 24'hfffffe, 3'h4, 24'h000001, 24'h0, 24'hffffff, 4'h2, 1'b0},
		'{24'hd2ffff, 3'h5, 24'h7f8001, 3'h5, 24'h7f8001, 24'h0, 24'h800000, 4'h3, 1'b0},
		'{24'h990100, 3'h2, 24'hffffff, 3'h0, 24'h0, 24'h000001, 24'h000000, 4'h4, 1'b1},
		'{24'h9c0000, 3'h4, 24'h800000, 3'h0, 24'h0, 24'h800000, 24'h000000, 4'h5, 1'b1},
		'{24'ha00000, 3'h5, 24'h000005, 3'h0, 24'h0, 24'h7ffffa, 24'h7fffff, 4'h8, 1'b1}};
	acd_core dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .instr_valid, .instr_word, .instr_mem_data, .instr_ready, .dec_op6,
		.dec_op12, .dec_op_long, .dec_op_ext, .dec_indirect, .dec_index, .dec_addr,
		.rf_rd_sel_a, .rf_rd_sel_b, .rf_rd_data_a, .rf_rd_data_b, .rf_wr_en, .rf_wr_sel,
		.rf_wr_data, .mem_wr_en, .mem_wr_data, .cond_flags, .irq);
	acd_rf_model u_rf (.clk, .sel_a(rf_rd_sel_a), .sel_b(rf_rd_sel_b), .rd_a(rf_rd_data_a),
		.rd_b(rf_rd_data_b), .wr_en(rf_wr_en), .wr_sel(rf_wr_sel), .wr_data(rf_wr_data));
	// ========
	// Free-running clock and a guard that cuts a hang short.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fail_count++;
			conclude();
		end
	end
	// ========
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One bus transfer; it waits for ready, so slow answers are fine too.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Offers a word until taken, then scrambles the lines so stale reuse shows.
	task automatic op(input logic [23:0] w, input logic [23:0] m);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_word <= w;
		instr_mem_data <= m;
		do @(posedge clk); while (instr_ready !== 1'b1);
		instr_valid <= 1'b0;
		instr_word <= ~w;
		instr_mem_data <= ~m;
		w_rf = 1'b0;
		w_mem = 1'b0;
		repeat (5) begin
			@(negedge clk);
			w_rf |= rf_wr_en;
			w_mem |= mem_wr_en;
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ========
	// Reset, table of cases, then skipped ops, interrupts and refusals.
	initial begin
		{nrst, psel, penable, pwrite, instr_valid, paddr, pwdata} = '0;
		{instr_word, instr_mem_data} = '0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd, 32'h1);
		foreach (rows[i]) begin
			u_rf.rf[rows[i].sa] = rows[i].va;
			u_rf.rf[rows[i].sb] = rows[i].vb;
			op(rows[i].w, rows[i].m);
			chk({30'h0, w_mem, w_rf}, {30'h0, rows[i].mw, !rows[i].mw});
			chk({8'h0, rows[i].mw ? mem_wr_data : rf_wr_data}, {8'h0, rows[i].d});
			chk({28'h0, cond_flags}, {28'h0, rows[i].c});
			if (!rows[i].mw)
				chk({29'h0, rf_wr_sel}, {29'h0, rows[i].sb});
		end
		op(24'hbc0000, 24'h000003);
		chk({30'h0, w_mem, w_rf}, 32'h0);
		chk({28'h0, cond_flags}, 32'h8);
		// A zero twelve-bit field marks an extended code; it is not handled here.
		op(24'h000005, 24'h000003);
		chk({30'h0, dec_op_long, dec_op_ext}, 32'h3);
		chk({26'h0, w_mem, w_rf, cond_flags}, 32'h8);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h7);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, 12'h008, 32'h4);
		repeat (2) @(negedge clk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, 12'h004, 32'h7);
		repeat (2) @(negedge clk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk(rd, 32'h007fffff);
		apb(1'b0, 12'h020, 32'h0);
		chk({err, rd[30:0]}, 32'h80000000);
		apb(1'b1, 12'h000, 32'hf);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h8);
		apb(1'b1, 12'h00c, 32'h0);
		@(posedge clk);
		instr_valid <= 1'b1;
		repeat (4) @(negedge clk);
		chk({31'h0, instr_ready}, 32'h0);
		@(posedge clk);
		instr_valid <= 1'b0;
		// Reset in mid-run must clear flags, ready and the interrupt line.
		@(posedge clk);
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		chk({26'h0, irq, cond_flags, instr_ready}, 32'h0);
		nrst <= 1'b1;
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0);
		conclude();
	end
endmodule
`default_nettype wire
